// [logic/add_exec_pkg.sv]
/*
 * constants for the addition execute block: opcode fields, phase codes,
 * status flag positions, apb register map and reset values.
 * assumes a single core clock and an apb master for the register port.
 */
// Operation
// - literal add sums accumulator with 8-bit literal, result into accumulator.
// - literal add decoded from upper byte 0000 1111, low byte literal.
// - register add decoded from top six bits 001001, then d, a, address.
// - destination bit zero sends the sum to the accumulator.
// - destination bit one writes the sum back to the addressed register.
// - bank bit zero uses access bank, one uses bank select register.
// - extended set, bank bit zero, address up to 95: indexed literal offset.
// - both adds update negative, overflow, carry, half carry and zero flags.
// - literal add: one word, one cycle, decode/read/compute/write phases.
// - register add: one cycle, decode/read/compute/write destination phases.
package add_exec_pkg;

    // opcode fields
    localparam logic [7:0] LIT_OPCODE = 8'h0f;
    localparam logic [5:0] REG_OPCODE = 6'h09;
    localparam int OPC_HI = 15;
    localparam int LIT_OPC_LO = 8;
    localparam int REG_OPC_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_HALF_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_SIGNED_WRAP = 3;
    localparam int FLAG_N = 4;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSN = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_BANK = 8'h0c;
    localparam logic [7:0] OFS_FSR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    localparam logic [7:0] OFS_MEMWR = 8'h1c;

    // control bits
    localparam int CTRL_EXT = 0;
    localparam int CTRL_GO = 1;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] FSR_RST = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;

    // result status bits
    localparam int RES_BUSY = 0;
    localparam int RES_ILLEGAL = 1;

    // one-hot phase codes of the instruction cycle
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_Q1 = 5'b00010,
        PH_Q2 = 5'b00100,
        PH_Q3 = 5'b01000,
        PH_Q4 = 5'b10000
    } phase_e;

endpackage : add_exec_pkg

// [logic/add_alu.sv]
/*
 * 8-bit adder with the five arithmetic status flags.
 * assumes operands are stable while the result is sampled.
 */
`timescale 1ns/10ps
`default_nettype none
module add_alu #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] op_a,
    input wire logic [WIDTH-1:0] op_b,
    output logic [WIDTH-1:0] sum,
    output logic [4:0] flags
);

    logic [WIDTH:0] full_sum;
    logic [4:0] low_sum;

    // carries from bit 7 and 3
    always_comb begin
        full_sum = {1'b0, op_a} + {1'b0, op_b};
        low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
        sum = full_sum[WIDTH-1:0];
        flags = '0;
        // all five flags from the sum
        flags[add_exec_pkg::FLAG_C] = full_sum[WIDTH];
        flags[add_exec_pkg::FLAG_HALF_CARRY] = low_sum[4];
        flags[add_exec_pkg::FLAG_Z] = (full_sum[WIDTH-1:0] == '0);
        flags[add_exec_pkg::FLAG_N] = full_sum[WIDTH-1];
        flags[add_exec_pkg::FLAG_SIGNED_WRAP] = (op_a[WIDTH-1] == op_b[WIDTH-1]) &&
                                       (full_sum[WIDTH-1] != op_a[WIDTH-1]);
    end

endmodule : add_alu
`default_nettype wire

// [logic/add_instruction_execute.sv]
/*
 * executes the literal add and register add instructions over four phases.
 * software loads an instruction, operands and bank state over apb and starts it.
 * data memory is a port: the read address is registered at the end of phase one, the data
 * is taken in phase two, a write strobe is given in phase four.
 */
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module add_instruction_execute #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [7:0] acc_out,
    output logic [4:0] status_out
);

    add_exec_pkg::phase_e phase_reg;
    logic [15:0] insn_reg;
    logic [7:0] acc_reg;
    logic [3:0] bank_select_reg;
    logic [7:0] fsr_reg;
    logic [4:0] status_reg;
    logic ext_reg;
    logic is_lit_reg;
    logic is_reg_reg;
    logic illegal_reg;
    logic [7:0] operand_reg;
    logic [7:0] sum_reg;
    logic [4:0] flags_reg;
    logic [7:0] mem_wr_reg;
    logic [7:0] alu_sum;
    logic [4:0] alu_flags;
    logic apb_wr;
    logic apb_rd;
    logic go;

    // decoding helpers
    function automatic logic dec_lit(input logic [15:0] w);
        return w[add_exec_pkg::OPC_HI:add_exec_pkg::LIT_OPC_LO] == add_exec_pkg::LIT_OPCODE;
    endfunction : dec_lit

    function automatic logic dec_reg(input logic [15:0] w);
        // top six bits select register add
        return w[add_exec_pkg::OPC_HI:add_exec_pkg::REG_OPC_LO] == add_exec_pkg::REG_OPCODE;
    endfunction : dec_reg

    function automatic logic [ADDR_W-1:0] eff_addr(input logic [15:0] w, input logic ext,
                                                    input logic [3:0] bank_sel, input logic [7:0] fsr);
        logic [7:0] f;
        f = w[7:0];
        if (!w[add_exec_pkg::BANK_BIT] && ext && f <= add_exec_pkg::INDEX_LIMIT) begin
            return ADDR_W'({bank_sel, fsr} + {4'h0, f});
        // bank bit selects access bank or general purpose bank
        end else if (w[add_exec_pkg::BANK_BIT]) begin
            return ADDR_W'({bank_sel, f});
        end else if (f < add_exec_pkg::ACCESS_SPLIT) begin
            return ADDR_W'({4'h0, f});
        end else begin
            return ADDR_W'({add_exec_pkg::ACCESS_HIGH_BANK, f});
        end
    endfunction : eff_addr

    add_alu #(
        .WIDTH(8)
    ) u_alu (
        .op_a(acc_reg),
        .op_b(operand_reg),
        .sum(alu_sum),
        .flags(alu_flags)
    );

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign go = apb_wr && paddr == add_exec_pkg::OFS_CTRL && pwdata[add_exec_pkg::CTRL_GO]
                && phase_reg == add_exec_pkg::PH_IDLE;

    // apb: ready every access phase, error on offsets above OFS_MEMWR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > add_exec_pkg::OFS_MEMWR;
        end
    end

    // apb read data, registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            unique case (paddr)
                add_exec_pkg::OFS_CTRL: prdata <= {31'h0, ext_reg};
                add_exec_pkg::OFS_INSN: prdata <= {16'h0, insn_reg};
                add_exec_pkg::OFS_ACC: prdata <= {24'h0, acc_reg};
                add_exec_pkg::OFS_BANK: prdata <= {28'h0, bank_select_reg};
                add_exec_pkg::OFS_FSR: prdata <= {24'h0, fsr_reg};
                add_exec_pkg::OFS_STATUS: prdata <= {27'h0, status_reg};
                add_exec_pkg::OFS_RESULT: prdata <= {30'h0, illegal_reg,
                                                     phase_reg != add_exec_pkg::PH_IDLE};
                add_exec_pkg::OFS_MEMWR: prdata <= {24'h0, mem_wr_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // software-loaded configuration, frozen while an instruction runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_reg <= 16'h0000;
            bank_select_reg <= add_exec_pkg::BANK_RST;
            fsr_reg <= add_exec_pkg::FSR_RST;
            ext_reg <= 1'b0;
        end else if (apb_wr && phase_reg == add_exec_pkg::PH_IDLE) begin
            unique case (paddr)
                add_exec_pkg::OFS_CTRL: ext_reg <= pwdata[add_exec_pkg::CTRL_EXT];
                add_exec_pkg::OFS_INSN: insn_reg <= pwdata[15:0];
                add_exec_pkg::OFS_BANK: bank_select_reg <= pwdata[3:0];
                add_exec_pkg::OFS_FSR: fsr_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // same four phases for register add
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= add_exec_pkg::PH_IDLE;
        end else begin
            unique case (phase_reg)
                add_exec_pkg::PH_IDLE: if (go) phase_reg <= add_exec_pkg::PH_Q1;
                add_exec_pkg::PH_Q1: phase_reg <= add_exec_pkg::PH_Q2;
                add_exec_pkg::PH_Q2: phase_reg <= add_exec_pkg::PH_Q3;
                add_exec_pkg::PH_Q3: phase_reg <= add_exec_pkg::PH_Q4;
                add_exec_pkg::PH_Q4: phase_reg <= add_exec_pkg::PH_IDLE;
                default: phase_reg <= add_exec_pkg::PH_IDLE;
            endcase
        end
    end

    // q1 decode and memory address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_lit_reg <= 1'b0;
            is_reg_reg <= 1'b0;
            illegal_reg <= 1'b0;
            mem_addr <= '0;
        end else if (phase_reg == add_exec_pkg::PH_Q1) begin
            is_lit_reg <= dec_lit(insn_reg);
            is_reg_reg <= dec_reg(insn_reg);
            illegal_reg <= !dec_lit(insn_reg) && !dec_reg(insn_reg);
            mem_addr <= eff_addr(insn_reg, ext_reg, bank_select_reg, fsr_reg);
        end
    end

    // q2 operand read: literal or memory data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_reg <= 8'h00;
        end else if (phase_reg == add_exec_pkg::PH_Q2) begin
            operand_reg <= is_lit_reg ? insn_reg[7:0] : mem_rdata;
        end
    end

    // q3 arithmetic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_reg <= 8'h00;
            flags_reg <= add_exec_pkg::STATUS_RST;
        end else if (phase_reg == add_exec_pkg::PH_Q3) begin
            sum_reg <= alu_sum;
            flags_reg <= alu_flags;
        end
    end

    // q4 accumulator and status write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= add_exec_pkg::ACC_RST;
            status_reg <= add_exec_pkg::STATUS_RST;
        end else if (phase_reg == add_exec_pkg::PH_Q4 && !illegal_reg) begin
            status_reg <= flags_reg;
            if (is_lit_reg || !insn_reg[add_exec_pkg::DEST_BIT]) begin
                acc_reg <= sum_reg;
            end
        end else if (apb_wr && paddr == add_exec_pkg::OFS_ACC && phase_reg == add_exec_pkg::PH_IDLE) begin
            acc_reg <= pwdata[7:0];
        end else if (apb_wr && paddr == add_exec_pkg::OFS_STATUS && phase_reg == add_exec_pkg::PH_IDLE) begin
            status_reg <= pwdata[4:0];
        end
    end

    // q4 memory write-back strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            mem_wr_reg <= 8'h00;
        end else begin
            mem_we <= phase_reg == add_exec_pkg::PH_Q3 && is_reg_reg && insn_reg[add_exec_pkg::DEST_BIT];
            if (phase_reg == add_exec_pkg::PH_Q3) begin
                mem_wdata <= alu_sum;
            end
            if (mem_we) begin
                mem_wr_reg <= mem_wdata;
            end
        end
    end

    // mirrors of architectural state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_out <= add_exec_pkg::ACC_RST;
            status_out <= add_exec_pkg::STATUS_RST;
        end else begin
            acc_out <= acc_reg;
            status_out <= status_reg;
        end
    end

    // checks
    sequence s_cycle;
        phase_reg == add_exec_pkg::PH_Q1 ##1 phase_reg == add_exec_pkg::PH_Q2
            ##1 phase_reg == add_exec_pkg::PH_Q3 ##1 phase_reg == add_exec_pkg::PH_Q4;
    endsequence

    a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> s_cycle ##1 phase_reg == add_exec_pkg::PH_IDLE)
        else $error("phase order broken");

    a_lit_acc: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q1 && dec_lit(insn_reg)) |=> ##3
        acc_reg == 8'($past(acc_reg, 3) + insn_reg[7:0]))
        else $error("literal add result wrong");

    a_dest_mem: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q1 && dec_reg(insn_reg) && insn_reg[add_exec_pkg::DEST_BIT])
        |=> ##2 mem_we ##1 $stable(acc_reg))
        else $error("memory destination not written");

    a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q1 && dec_reg(insn_reg) && !insn_reg[add_exec_pkg::DEST_BIT])
        |=> ##2 !mem_we ##1 acc_reg == 8'($past(acc_reg, 3) + $past(operand_reg, 1)))
        else $error("accumulator destination wrong");

    a_we_only_q4: assert property (@(posedge pclk) disable iff (!presetn)
        mem_we |-> phase_reg == add_exec_pkg::PH_Q4 && is_reg_reg)
        else $error("stray memory write");

    a_bank_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q1 && insn_reg[add_exec_pkg::BANK_BIT])
        |=> mem_addr == ADDR_W'({bank_select_reg, insn_reg[7:0]}))
        else $error("banked address wrong");

    a_index_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q1 && ext_reg && !insn_reg[add_exec_pkg::BANK_BIT]
         && insn_reg[7:0] <= add_exec_pkg::INDEX_LIMIT)
        |=> mem_addr == ADDR_W'({bank_select_reg, fsr_reg} + {4'h0, insn_reg[7:0]}))
        else $error("indexed address wrong");

    a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == add_exec_pkg::PH_Q4 && !illegal_reg)
        |=> status_reg[add_exec_pkg::FLAG_Z] == (sum_reg == 8'h00)
            && status_reg[add_exec_pkg::FLAG_N] == sum_reg[7])
        else $error("zero or negative flag wrong");

    a_carry_flag: assert property (@(posedge pclk) disable iff (!presetn)
        phase_reg == add_exec_pkg::PH_Q3 |=>
        flags_reg[add_exec_pkg::FLAG_C] == (9'($past(acc_reg)) + 9'($past(operand_reg)) > 9'h0ff))
        else $error("carry flag wrong");

    a_half_carry: assert property (@(posedge pclk) disable iff (!presetn)
        phase_reg == add_exec_pkg::PH_Q3 |=> flags_reg[add_exec_pkg::FLAG_HALF_CARRY] ==
        (5'($past(acc_reg[3:0])) + 5'($past(operand_reg[3:0])) > 5'h0f))
        else $error("half carry flag wrong");

    a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
        phase_reg == add_exec_pkg::PH_Q3 |=> flags_reg[add_exec_pkg::FLAG_SIGNED_WRAP] ==
        ($past(acc_reg[7]) == $past(operand_reg[7]) && sum_reg[7] != $past(acc_reg[7])))
        else $error("signed wrap flag wrong");

endmodule : add_instruction_execute
`default_nettype wire

// [tb/data_mem_model.sv]
/*
 * data memory seen by the execute block: byte cells, read at once, written
 * on the write strobe. assumes one core clock and a registered address.
 */
`timescale 1ns/10ps
`default_nettype none
module data_mem_model #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_rdata,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we
);
    logic [7:0] cells [0:(1<<ADDR_W)-1];
    int n_writes;

    // fill with a pattern so a wrong address reads a wrong byte
    initial begin
        n_writes = 0;
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            cells[i] = 8'(i ^ (i >> 5));
        end
    end

    assign mem_rdata = cells[mem_addr];

    // write back on strobe, counted per cycle
    always @(posedge pclk) begin
        if (mem_we === 1'b1) begin
            cells[mem_addr] <= mem_wdata;
            n_writes <= n_writes + 1;
        end
    end
endmodule : data_mem_model
`default_nettype wire

// [tb/add_instruction_execute_bench.sv]
/*
 * self-checking bench for the addition execute block over apb.
 * assumes the data memory model answers reads in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module add_instruction_execute_bench;
    localparam int AW = 12;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_rdata;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic [7:0] acc_out;
    logic [4:0] status_out;
    int n_mismatch = 0;
    int checks = 0;

    always #12.5 pclk = ~pclk;

    add_instruction_execute #(.ADDR_W(AW)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .acc_out(acc_out), .status_out(status_out));

    data_mem_model #(.ADDR_W(AW)) mem_i (.pclk(pclk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wdata(mem_wdata), .mem_we(mem_we));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // apb master: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
        chk("pslverr", {31'h0, a > add_exec_pkg::OFS_MEMWR}, {31'h0, err});
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    function automatic logic [4:0] flags_of(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] f;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        f = 5'h00;
        f[add_exec_pkg::FLAG_C] = s[8];
        f[add_exec_pkg::FLAG_HALF_CARRY] = h[4];
        f[add_exec_pkg::FLAG_Z] = (s[7:0] == 8'h00);
        f[add_exec_pkg::FLAG_SIGNED_WRAP] = (a[7] == b[7]) && (s[7] != a[7]);
        f[add_exec_pkg::FLAG_N] = s[7];
        return f;
    endfunction : flags_of

    // load state, start, poll until idle
    task automatic run(input logic [15:0] insn, input logic ext, input logic [7:0] acc0,
                       input logic [3:0] bank, input logic [7:0] fsr, output logic [31:0] res);
        int p;
        wr(add_exec_pkg::OFS_ACC, {24'h0, acc0});
        wr(add_exec_pkg::OFS_BANK, {28'h0, bank});
        wr(add_exec_pkg::OFS_FSR, {24'h0, fsr});
        wr(add_exec_pkg::OFS_INSN, {16'h0, insn});
        wr(add_exec_pkg::OFS_CTRL, {30'h0, 1'b1, ext});
        p = 0;
        do begin
            rd(add_exec_pkg::OFS_RESULT, res);
            p++;
        end while (res[0] !== 1'b0 && p < 20);
        chk("polls", 32'd2, 32'(p));
    endtask : run

    task automatic fin(input logic [7:0] e, input logic [7:0] a, input logic [7:0] b);
        logic [31:0] q;
        rd(add_exec_pkg::OFS_ACC, q);
        chk("acc", {24'h0, e}, q);
        rd(add_exec_pkg::OFS_STATUS, q);
        chk("status", {27'h0, flags_of(a, b)}, q);
        chk("acc_out", {24'h0, e}, {24'h0, acc_out});
        chk("status_out", {27'h0, flags_of(a, b)}, {27'h0, status_out});
    endtask : fin

    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd(add_exec_pkg::OFS_ACC, q);
        chk("acc rst", 32'h0, q);
        rd(add_exec_pkg::OFS_STATUS, q);
        chk("status rst", 32'h0, q);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask : t_reset

    task automatic lit(input logic [7:0] a, input logic [7:0] k);
        logic [31:0] q;
        int w0;
        w0 = mem_i.n_writes;
        run({8'h0f, k}, 1'b0, a, 4'h0, 8'h00, q);
        fin(8'(a + k), a, k);
        chk("lit illegal", 32'h0, {31'h0, q[1]});
        chk("lit writes", 32'(w0), 32'(mem_i.n_writes));
    endtask : lit

    task automatic regop(input logic d, input logic a, input logic ext, input logic [3:0] bank,
                         input logic [7:0] fsr, input logic [7:0] f, input logic [7:0] acc0,
                         input logic [7:0] mv, input logic [AW-1:0] ea);
        logic [31:0] q;
        logic [7:0] s;
        int w0;
        mem_i.cells[ea] = mv;
        w0 = mem_i.n_writes;
        s = acc0 + mv;
        run({6'b001001, d, a, f}, ext, acc0, bank, fsr, q);
        fin(d ? acc0 : s, acc0, mv);
        chk("reg illegal", 32'h0, {31'h0, q[1]});
        if (d) begin
            rd(add_exec_pkg::OFS_MEMWR, q);
            chk("memwr", {24'h0, s}, q);
        end
        chk("cell", {24'h0, d ? s : mv}, {24'h0, mem_i.cells[ea]});
        chk("reg writes", 32'(w0 + d), 32'(mem_i.n_writes));
    endtask : regop

    task automatic t_illegal();
        logic [31:0] q;
        int w0;
        w0 = mem_i.n_writes;
        run(16'h1234, 1'b0, 8'h33, 4'h0, 8'h00, q);
        chk("illegal", 32'h1, {31'h0, q[1]});
        rd(add_exec_pkg::OFS_ACC, q);
        chk("illegal acc", 32'h33, q);
        chk("illegal writes", 32'(w0), 32'(mem_i.n_writes));
    endtask : t_illegal

    // watchdog against a hung handshake
    initial begin
        repeat (8000) @(posedge pclk);
        n_mismatch++;
        results();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        lit(8'h10, 8'h15);
        lit(8'hff, 8'h01);
        lit(8'h7f, 8'h01);
        lit(8'h80, 8'h80);
        lit(8'h08, 8'h08);
        regop(0, 0, 0, 4'h0, 8'h00, 8'h20, 8'h17, 8'hc2, 12'h020);
        regop(1, 0, 0, 4'h3, 8'h00, 8'h80, 8'h01, 8'hff, 12'hf80);
        regop(1, 0, 0, 4'h3, 8'h00, 8'h5f, 8'h09, 8'h07, 12'h05f);
        regop(1, 1, 0, 4'h5, 8'h00, 8'h33, 8'h40, 8'h40, 12'h533);
        regop(0, 1, 1, 4'h5, 8'h40, 8'hf0, 8'h88, 8'h99, 12'h5f0);
        regop(1, 0, 1, 4'h1, 8'h40, 8'h10, 8'h21, 8'h12, 12'h150);
        regop(1, 0, 1, 4'h1, 8'h40, 8'h5f, 8'h0f, 8'h01, 12'h19f);
        regop(0, 0, 1, 4'h1, 8'h40, 8'h60, 8'h50, 8'h30, 12'hf60);
        t_illegal();
        results();
    end
endmodule : add_instruction_execute_bench
`default_nettype wire
